//--- logic/sync_header_gen.sv
`timescale 1ns/1ps
module sync_header_gen
   import shcf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_link_en,
   input wire logic i_fec_mode,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [BLK_W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output tx_blk_t o_out_blk,
   output logic [4:0] o_blk_idx
);
   ////////////////////////////////////////////////////////////////////////
   // functions

   // bit serial division, data msb goes first
   function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] s,
                                                 input logic [BLK_W-1:0] d);
      logic [CRC_W-1:0] r;
      logic fb;
      r = s;
      for (int i = BLK_W - 1; i >= 0; i--) begin
         fb = d[i] ^ r[CRC_W-1];
         r = {r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
      end
      return r;
   endfunction

   function automatic logic [FEC_W-1:0] fec_step(input logic [FEC_W-1:0] s,
                                                 input logic [BLK_W-1:0] d);
      logic [FEC_W-1:0] r;
      logic fb;
      r = s;
      for (int i = BLK_W - 1; i >= 0; i--) begin
         fb = d[i] ^ r[FEC_W-1];
         r = {r[FEC_W-2:0], 1'b0} ^ (fb ? FEC_POLY : FEC_INIT);
      end
      return r;
   endfunction

   // 32-bit stream word, index n is carried by block n
   function automatic logic [31:0] stream_word(input par_mode_t m,
                                               input logic [CRC_W-1:0] c,
                                               input logic [FEC_W-1:0] f);
      logic [31:0] w;
      w = PILOT_BITS;
      if (m == PAR_FEC) begin
         for (int i = 0; i < 22; i++) begin
            w[i] = f[FEC_W-1-i];
         end
         w[23] = f[3];
         w[26:24] = {f[0], f[1], f[2]};
      end else begin
         w = w | CRC_ONES_MASK;
         w[2:0] = {c[9], c[10], c[11]};
         w[6:4] = {c[6], c[7], c[8]};
         w[10:8] = {c[3], c[4], c[5]};
         w[14:12] = {c[0], c[1], c[2]};
         w = w & ~CMD_MASK;
      end
      w[EOEMB_POS] = 1'b1;
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic en_meta_q;
   logic en_sync_q;
   logic fec_meta_q;
   logic fec_sync_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_meta_q <= 1'b0;
         en_sync_q <= 1'b0;
         fec_meta_q <= 1'b0;
         fec_sync_q <= 1'b0;
      end else begin
         en_meta_q <= i_link_en;
         en_sync_q <= en_meta_q;
         fec_meta_q <= i_fec_mode;
         fec_sync_q <= fec_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state and mode

   run_state_t state_q;
   par_mode_t mode_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (en_sync_q) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (!en_sync_q) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // mode only follows the pin while the link is down
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_q <= PAR_CRC;
      end else if (state_q == ST_IDLE) begin
         mode_q <= fec_sync_q ? PAR_FEC : PAR_CRC;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // input buffer, back-pressure reaches the source

   logic fifo_vld;
   logic [BLK_W-1:0] fifo_data;
   logic load;
   logic run;
   logic out_valid_q;

   shcf_fifo #(
      .WIDTH(BLK_W),
      .DEPTH(FIFO_DEPTH)
   ) i_shcf_fifo (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_wr_valid(i_in_valid),
      .o_wr_ready(o_in_ready),
      .i_wr_data(i_in_data),
      .o_rd_valid(fifo_vld),
      .i_rd_ready(load),
      .o_rd_data(fifo_data)
   );

   assign run = (state_q == ST_RUN) && en_sync_q;
   // take a block when the output stage is free or draining
   assign load = run && fifo_vld && (!out_valid_q || i_out_ready);

   ////////////////////////////////////////////////////////////////////////
   // parity generators

   logic [4:0] idx_q;
   logic [CRC_W-1:0] crc_q;
   logic [FEC_W-1:0] fec_q;
   logic [CRC_W-1:0] crc_d;
   logic [FEC_W-1:0] fec_d;
   logic [CRC_W-1:0] crc_par_q;
   logic [FEC_W-1:0] fec_par_q;
   logic last_blk;

   // both codes run on every block; mode only picks the mapping
   assign crc_d = crc_step(crc_q, fifo_data);
   assign fec_d = fec_step(fec_q, fifo_data);
   assign last_blk = idx_q == LAST_BLK;

   // block counter within a multiblock
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         idx_q <= '0;
      end else if (!run) begin
         idx_q <= '0;
      end else if (load) begin
         idx_q <= idx_q + BLK_STEP;
      end
   end

   // running division, cleared at each multiblock boundary
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         crc_q <= CRC_INIT;
         fec_q <= FEC_INIT;
      end else if (!run || (load && last_blk)) begin
         crc_q <= CRC_INIT;
         fec_q <= FEC_INIT;
      end else if (load) begin
         crc_q <= crc_d;
         fec_q <= fec_d;
      end
   end

   // finished parity waits one multiblock, so a receiver sees it late
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         crc_par_q <= CRC_INIT;
         fec_par_q <= FEC_INIT;
      end else if (!run) begin
         crc_par_q <= CRC_INIT;
         fec_par_q <= FEC_INIT;
      end else if (load && last_blk) begin
         crc_par_q <= crc_d;
         fec_par_q <= fec_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output stage

   logic [31:0] stream;
   logic stream_bit;

   assign stream = stream_word(mode_q, crc_par_q, fec_par_q);
   assign stream_bit = stream[idx_q];

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         out_valid_q <= 1'b0;
      end else if (!run) begin
         out_valid_q <= 1'b0;
      end else if (load) begin
         out_valid_q <= 1'b1;
      end else if (i_out_ready) begin
         out_valid_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_out_blk <= '0;
         o_blk_idx <= '0;
      end else if (load) begin
         o_out_blk.sh <= stream_bit ? SH_ONE : SH_ZERO;
         o_out_blk.data <= fifo_data;
         o_blk_idx <= idx_q;
      end
   end

   assign o_out_valid = out_valid_q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic fire;
   assign fire = out_valid_q && i_out_ready;

   property p_pilot_zero;
      @(posedge i_clk) disable iff (!i_rst_n)
      out_valid_q && o_blk_idx >= PILOT_LO && o_blk_idx <= PILOT_HI |-> o_out_blk.sh == SH_ZERO;
   endproperty
   a_pilot_zero: assert property (p_pilot_zero) else $error("pilot zero wrong");

   property p_pilot_end;
      @(posedge i_clk) disable iff (!i_rst_n)
      out_valid_q && o_blk_idx == LAST_BLK |-> o_out_blk.sh == SH_ONE;
   endproperty
   a_pilot_end: assert property (p_pilot_end) else $error("pilot end wrong");

   property p_eoemb;
      @(posedge i_clk) disable iff (!i_rst_n)
      out_valid_q && o_blk_idx == EOEMB_POS |-> o_out_blk.sh == SH_ONE;
   endproperty
   a_eoemb: assert property (p_eoemb) else $error("eoemb bit not one");
   property p_crc_ones;
      @(posedge i_clk) disable iff (!i_rst_n)
      out_valid_q && mode_q == PAR_CRC && CRC_ONES_MASK[o_blk_idx] |-> o_out_blk.sh == SH_ONE;
   endproperty
   a_crc_ones: assert property (p_crc_ones) else $error("fixed one missing");
   property p_cmd_zero;
      @(posedge i_clk) disable iff (!i_rst_n)
      out_valid_q && mode_q == PAR_CRC && CMD_MASK[o_blk_idx] |-> o_out_blk.sh == SH_ZERO;
   endproperty
   a_cmd_zero: assert property (p_cmd_zero) else $error("command bit set");

   property p_clear;
      @(posedge i_clk) disable iff (!i_rst_n)
      load && last_blk |=> crc_q == CRC_INIT && fec_q == FEC_INIT && idx_q == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("state not cleared");
   property p_capture;
      @(posedge i_clk) disable iff (!i_rst_n)
      load && last_blk && run ##1 run |-> fec_par_q == $past(fec_d) && crc_par_q == $past(crc_d);
   endproperty
   a_capture: assert property (p_capture) else $error("parity not captured");

   property p_header;
      @(posedge i_clk) disable iff (!i_rst_n)
      out_valid_q |-> o_out_blk.sh == SH_ONE || o_out_blk.sh == SH_ZERO;
   endproperty
   a_header: assert property (p_header) else $error("bad header");

   property p_mode_hold;
      @(posedge i_clk) disable iff (!i_rst_n)
      state_q == ST_RUN ##1 state_q == ST_RUN |-> $stable(mode_q);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved");

   property p_order;
      @(posedge i_clk) disable iff (!i_rst_n)
      load ##1 load |=> o_blk_idx == $past(o_blk_idx) + BLK_STEP;
   endproperty
   // the index of the second of two back-to-back loads shows one cycle after it
   a_order: assert property (p_order) else $error("block order broken");
   c_mb_end: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      fire && o_blk_idx == LAST_BLK);
   c_fec: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      fire && mode_q == PAR_FEC);
   c_full: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      i_in_valid && !o_in_ready);
endmodule

//--- logic/shcf_pkg.sv
package shcf_pkg;
   // block and multiblock geometry
   localparam int BLK_W = 64;
   localparam int CRC_W = 12;
   localparam int FEC_W = 26;
   localparam int FIFO_DEPTH = 8;
   localparam logic [4:0] LAST_BLK = 5'h1f;
   localparam logic [4:0] EOEMB_POS = 5'h16;
   localparam logic [4:0] PILOT_LO = 5'h1b;
   localparam logic [4:0] PILOT_HI = 5'h1e;
   localparam logic [4:0] BLK_STEP = 5'h01;
   // generator polynomials, leading term implied
   localparam logic [CRC_W-1:0] CRC_POLY = 12'h987;
   localparam logic [FEC_W-1:0] FEC_POLY = 26'h0220211;
   localparam logic [CRC_W-1:0] CRC_INIT = 12'h000;
   localparam logic [FEC_W-1:0] FEC_INIT = 26'h0000000;
   // stream positions; the ones and command masks apply in crc mode only, the pilot in both modes
   localparam logic [31:0] CRC_ONES_MASK = 32'h00a88888;
   localparam logic [31:0] CMD_MASK = 32'h07170000;
   localparam logic [31:0] PILOT_MASK = 32'hf8000000;
   localparam logic [31:0] PILOT_BITS = 32'h80000000;
   // header codes, left bit sent first
   localparam logic [1:0] SH_ONE = 2'h1;
   localparam logic [1:0] SH_ZERO = 2'h2;

   typedef struct packed {
      logic [1:0] sh;
      logic [BLK_W-1:0] data;
   } tx_blk_t;

   typedef enum logic {
      PAR_CRC,
      PAR_FEC
   } par_mode_t;

   typedef enum {
      ST_IDLE,
      ST_RUN
   } run_state_t;
endpackage

//--- logic/shcf_fifo.sv
`timescale 1ns/1ps
module shcf_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [WIDTH-1:0] o_rd_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_q;
   logic [AW:0] rd_ptr_q;
   logic wr_fire;
   logic rd_fire;

   // extra pointer bit tells full from empty
   assign o_wr_ready = (wr_ptr_q - rd_ptr_q) != (AW+1)'(DEPTH);
   assign o_rd_valid = wr_ptr_q != rd_ptr_q;
   assign wr_fire = i_wr_valid && o_wr_ready;
   assign rd_fire = o_rd_valid && i_rd_ready;
   assign o_rd_data = mem[rd_ptr_q[AW-1:0]];

   // storage, no reset needed on data
   always_ff @(posedge i_clk) begin
      if (wr_fire) begin
         mem[wr_ptr_q[AW-1:0]] <= i_wr_data;
      end
   end

   // pointers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (wr_fire) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (rd_fire) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
      end
   end
endmodule

//--- testbench/shcf_rx_model.sv
`timescale 1ns/1ps
// far-side receiver: rebuilds the header stream and its own parity words
module shcf_rx_model
   import shcf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire tx_blk_t i_blk,
   input wire logic i_stall,
   input wire logic i_flip,
   input wire logic i_fec,
   output logic o_ready,
   output logic [31:0] o_stream,
   output logic [CRC_W-1:0] o_crc_prev,
   output logic [FEC_W-1:0] o_fec_prev,
   output logic [7:0] o_mb_count,
   output logic o_hdr_bad,
   output logic o_released
);
   logic [4:0] cnt_q;
   logic [31:0] acc_q;
   logic [CRC_W-1:0] crc_q;
   logic [CRC_W-1:0] crc_last_q;
   logic [FEC_W-1:0] fec_q;
   logic [FEC_W-1:0] fec_last_q;
   logic [BLK_W-1:0] rx_data;
   logic burst;
   logic pilot_good;
   logic pilot_seen_q;
   logic aligned_q;

   // msb-first division, one block per call; width w picks the register top
   function automatic logic [FEC_W-1:0] lfsr(input logic [FEC_W-1:0] s,
      input logic [FEC_W-1:0] poly, input int w, input logic [BLK_W-1:0] d);
      logic fb;
      for (int i = BLK_W - 1; i >= 0; i--) begin
         fb = d[i] ^ s[w-1];
         s = (s << 1) ^ (fb ? poly : 26'h0);
      end
      return s & ((26'h1 << w) - 26'h1);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // stalls only when the bench asks; a flip models a line error
   assign o_ready = !i_stall;
   assign burst = i_flip && cnt_q == 5'h00 && o_mb_count == 8'h00;
   // nine bits from the very first one: the longest burst the fec code must mend
   assign rx_data = i_blk.data ^ {{9{burst}}, 55'h0};
   // pilot 00001: bits 27..30 gathered so far, bit 31 arriving now
   assign pilot_good = (acc_q[30:27] == 4'h0) && (i_blk.sh == SH_ONE);

   // block boundaries taken from the first block after enable; the pilot confirms them
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 5'h00;
         acc_q <= 32'h0;
         crc_q <= 12'h000;
         crc_last_q <= 12'h000;
         fec_q <= 26'h0;
         fec_last_q <= 26'h0;
         o_stream <= 32'h0;
         o_crc_prev <= 12'h000;
         o_fec_prev <= 26'h0;
         o_mb_count <= 8'h00;
         o_hdr_bad <= 1'b0;
         pilot_seen_q <= 1'b0;
         aligned_q <= 1'b0;
         o_released <= 1'b0;
      end else if (i_valid && o_ready) begin
         cnt_q <= cnt_q + 5'h01;
         acc_q[cnt_q] <= (i_blk.sh == 2'h1);
         if (i_blk.sh[1] == i_blk.sh[0]) begin
            o_hdr_bad <= 1'b1;
         end
         // one lane only: buffering starts and the release point (lemc edge, rbd zero,
         // clear of any arrival spread) falls on the next multiblock start
         if (cnt_q == 5'h00 && aligned_q) begin
            o_released <= 1'b1;
         end
         if (cnt_q == 5'h1f) begin
            o_stream <= {i_blk.sh == 2'h1, acc_q[30:0]};
            o_crc_prev <= crc_last_q;
            o_fec_prev <= fec_last_q;
            crc_last_q <= CRC_W'(lfsr(FEC_W'(crc_q), 26'h0000987, CRC_W, rx_data));
            fec_last_q <= lfsr(fec_q, 26'h0220211, FEC_W, rx_data);
            crc_q <= 12'h000;
            fec_q <= 26'h0;
            o_mb_count <= o_mb_count + 8'h01;
            pilot_seen_q <= pilot_good;
            // crc: one good pilot is enough; fec: it must recur at the same place
            if (pilot_good && (!i_fec || pilot_seen_q)) begin
               aligned_q <= 1'b1;
            end
            if (!pilot_good) begin
               o_hdr_bad <= 1'b1;
            end
         end else begin
            crc_q <= CRC_W'(lfsr(FEC_W'(crc_q), 26'h0000987, CRC_W, rx_data));
            fec_q <= lfsr(fec_q, 26'h0220211, FEC_W, rx_data);
         end
      end
   end
endmodule

//--- testbench/sync_header_crc_fec_gen_bench.sv
`timescale 1ns/1ps
module sync_header_crc_fec_gen_bench
   import shcf_pkg::*;
;
   logic i_clk;
   logic i_rst_n;
   logic link_en;
   logic fec_mode;
   logic in_valid;
   logic in_ready;
   logic out_valid;
   logic rx_ready;
   logic stall;
   logic flip;
   logic hdr_bad;
   logic released;
   logic [BLK_W-1:0] in_data;
   tx_blk_t out_blk;
   logic [4:0] blk_idx;
   logic [31:0] stream;
   logic [CRC_W-1:0] crc_prev;
   logic [FEC_W-1:0] fec_prev;
   logic [7:0] mb_count;
   int bad_count;
   int samples_checked;

   sync_header_gen i_sync_header_gen (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_link_en(link_en),
      .i_fec_mode(fec_mode), .i_in_valid(in_valid), .o_in_ready(in_ready), .i_in_data(in_data),
      .o_out_valid(out_valid), .i_out_ready(rx_ready), .o_out_blk(out_blk), .o_blk_idx(blk_idx));

   shcf_rx_model i_shcf_rx_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(out_valid),
      .i_blk(out_blk), .i_stall(stall), .i_flip(flip), .i_fec(fec_mode), .o_ready(rx_ready),
      .o_stream(stream), .o_crc_prev(crc_prev), .o_fec_prev(fec_prev), .o_mb_count(mb_count),
      .o_hdr_bad(hdr_bad), .o_released(released));

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask

   // expected header stream for a given parity word of the previous multiblock
   function automatic logic [31:0] exp_stream(input logic fec, input logic [CRC_W-1:0] c,
      input logic [FEC_W-1:0] f);
      logic [31:0] s;
      s = 32'h80400000;
      if (fec) begin
         for (int i = 0; i < 22; i++) s[i] = f[25-i];
         s[26:23] = {f[0], f[1], f[2], f[3]};
      end else begin
         s = s | 32'h00a88888;
         for (int i = 0; i < 12; i++) s[i+i/3] = c[11-i];
      end
      return s;
   endfunction

   task automatic do_reset();
      link_en = 1'b0;
      in_valid = 1'b0;
      i_rst_n = 1'b0;
      repeat (10) @(negedge i_clk);
      i_rst_n = 1'b1;
   endtask

   // fill the buffer while off until refused, then stream three multiblocks
   // with the receiver stalling every third cycle
   task automatic run(input logic fec, input logic err);
      int sent;
      int seen;
      logic rdy;
      logic ok;
      sent = 0;
      seen = 0;
      rdy = 1'b0;
      fec_mode = fec;
      flip = err;
      do_reset();
      for (int cyc = 0; cyc < 4000 && seen < 3; cyc++) begin
         @(negedge i_clk);
         if (in_valid && rdy) sent++;
         if (!link_en && !in_ready) begin
            check(sent, FIFO_DEPTH, "fill depth");
            check(out_valid, 1'b0, "output while off");
            link_en = 1'b1;
         end
         rdy = in_ready;
         in_valid = sent < 96;
         in_data = {32'(sent) * 32'h9e3779b9, 32'(sent) ^ 32'h5a5a0f0f};
         stall = (cyc % 3 == 0);
         if (mb_count != seen) begin
            seen = mb_count;
            ok = stream === exp_stream(fec, crc_prev, fec_prev);
            check(ok, !(err && seen == 2), "stream");
         end
      end
      check(seen, 3, "multiblocks");
      check(released, 1'b1, "buffer release");
      check(hdr_bad, 1'b0, "header code");
      repeat (4) @(negedge i_clk);
      check(out_valid, 1'b0, "drained");
      check(in_ready, 1'b1, "empty");
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      do_reset();
      @(negedge i_clk);
      check(out_valid, 1'b0, "valid at reset");
      check(in_ready, 1'b1, "ready at reset");
      check(blk_idx, 5'h00, "index at reset");
      $display("test reset done");
   endtask

   task automatic t_crc();
      run(1'b0, 1'b0);
      $display("test crc done");
   endtask

   task automatic t_fec();
      run(1'b1, 1'b0);
      $display("test fec done");
   endtask

   // a nine-bit burst from the first bit must show as a parity difference one multiblock later
   task automatic t_crc_err();
      run(1'b0, 1'b1);
      $display("test crc error done");
   endtask

   // a nine-bit burst must leave a nonzero syndrome one multiblock later
   task automatic t_fec_err();
      run(1'b1, 1'b1);
      $display("test fec error done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // about 700 cycles expected; generous margin before calling it a hang
   initial begin
      repeat (20000) @(posedge i_clk);
      bad_count++;
      results();
   end

   initial begin
      fec_mode = 1'b0;
      in_data = 64'h0;
      stall = 1'b0;
      flip = 1'b0;
      bad_count = 0;
      samples_checked = 0;
      t_reset();
      t_crc();
      t_fec();
      t_crc_err();
      t_fec_err();
      results();
   end
endmodule
